// >>> hw/hssf_top.sv
`timescale 1ns/10ps

module hssf_top #(
    parameter bit RETRY_VARIANT = 1'b1,
    parameter bit EN_ACTIVE_HIGH = 1'b1,
    parameter logic [6:0] DEV_ADDR = hssf_pkg::DEV_ADDR_DEF
) (
    input wire logic clk_i,              // Core clock, 40 MHz
    input wire logic nrst_i,             // Asynchronous reset, active low
    input wire logic link_clk_i,         // Clock of the serial link logic
    input wire logic enable_input_pin_i, // Enable pin, polarity set by EN_ACTIVE_HIGH
    input wire logic conv_valid_i,       // Level pulsing high once per finished conversion, counted on its rising edge
    input wire logic conv_over_i,        // Conversion result is above the alert threshold
    input wire logic analog_trip_i,      // Output is off from an analog overcurrent
    input wire logic insert_fail_i,      // Hot swap attempt has failed
    input wire logic scl_i,              // Serial clock pin
    input wire logic sda_i,              // Serial data pin, input side
    output logic sda_o,                  // Serial data pin, output value
    output logic sda_oen_o,              // Serial data pin enable, low drives
    output logic hs_enable_o             // Hot swap output on
);
    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Core domain.

    hssf_pkg::hssf_core_t core_r;
    hssf_pkg::hssf_core_t core_nxt;
    hssf_pkg::hssf_pins_t pins_s;
    hssf_pkg::hssf_link_t link_r;
    hssf_pkg::hssf_link_t link_nxt;
    logic wr_tgl_s;
    logic ack_s;
    logic snap_tgl_s;
    logic scl_s;
    logic sda_s;
    logic conv_strobe;
    logic pin_deasserted;
    logic clr;
    logic conv_alert_set;
    logic off_alert_set;

    // The enable pin resets to its asserted level, so that no off alert is raised by reset alone.
    hssf_sync #(.WIDTH(5), .RST_VAL({EN_ACTIVE_HIGH, 4'h0})) u_pin_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i({enable_input_pin_i, conv_valid_i, conv_over_i, analog_trip_i, insert_fail_i}),
        .q_o(pins_s)
    );

    hssf_sync #(.WIDTH(2)) u_core_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i({link_r.wr_tgl, link_r.seen}),
        .q_o({wr_tgl_s, ack_s})
    );

    always_comb begin
        core_nxt = core_r;
        conv_strobe = pins_s.conv_valid & ~core_r.conv_prev;
        pin_deasserted = EN_ACTIVE_HIGH ? ~pins_s.enable_input_pin : pins_s.enable_input_pin;
        clr = core_r.alert_en[hssf_pkg::AEN_CLEAR_BIT];
        core_nxt.conv_prev = pins_s.conv_valid;
        if (conv_strobe) begin
            core_nxt.oc_hist = {core_r.oc_hist[1:0], pins_s.conv_over};
        end
        core_nxt.status.conversion_overcurrent_now = &core_nxt.oc_hist;
        conv_alert_set = core_r.status.conversion_overcurrent_now & core_r.alert_en[hssf_pkg::AEN_CONV_BIT];
        off_alert_set = core_r.status.off_status & core_r.alert_en[hssf_pkg::AEN_OFF_BIT];
        // A set in the cycle of a clear wins, so a persisting source reappears at once.
        core_nxt.status.conv_alert = (core_r.status.conv_alert & ~clr) | conv_alert_set;
        core_nxt.status.insertion_fail_alert = (core_r.status.insertion_fail_alert & ~clr)
            | pins_s.insert_fail;
        core_nxt.status.off_alert = (core_r.status.off_alert & ~clr) | off_alert_set;
        if (!RETRY_VARIANT && core_r.alert_en[hssf_pkg::AEN_INS_BIT]) begin
            core_nxt.status.analog_trip_off_state = core_nxt.status.insertion_fail_alert;
        end else begin
            core_nxt.status.analog_trip_off_state = pins_s.analog_trip;
        end
        core_nxt.status.off_status = pin_deasserted | core_r.control[hssf_pkg::CTL_SW_OFF_BIT];
        core_nxt.status.spare = 2'h0;
        core_nxt.hs_on = ~core_nxt.status.off_status;
        if (clr) begin
            core_nxt.alert_en[hssf_pkg::AEN_CLEAR_BIT] = 1'b0;
        end
        // Write data is held stable by the link until the next write toggle.
        if (wr_tgl_s != core_r.wr_seen) begin
            core_nxt.wr_seen = wr_tgl_s;
            if (link_r.wr_ptr == hssf_pkg::ALERT_EN_IDX) begin
                core_nxt.alert_en = link_r.wr_data;
            end else if (link_r.wr_ptr == hssf_pkg::CONTROL_IDX) begin
                core_nxt.control = link_r.wr_data;
            end
        end
        // A new snapshot is offered only once the link has taken the last one.
        if (ack_s == core_r.snap_tgl && core_r.snap != core_r.status) begin
            core_nxt.snap = core_r.status;
            core_nxt.snap_tgl = ~core_r.snap_tgl;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_r <= '{
                oc_hist: hssf_pkg::OC_HIST_RST,
                conv_prev: 1'b0,
                status: hssf_pkg::STATUS_RST,
                alert_en: hssf_pkg::ALERT_EN_RST,
                control: hssf_pkg::CONTROL_RST,
                wr_seen: 1'b0,
                snap: hssf_pkg::STATUS_RST,
                snap_tgl: 1'b0,
                hs_on: 1'b0
            };
        end else begin
            core_r <= core_nxt;
        end
    end

    assign hs_enable_o = core_r.hs_on;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Link domain: serial slave that answers reads with the status byte.

    hssf_sync #(.WIDTH(3), .RST_VAL(3'h6)) u_link_sync (
        .clk_i(link_clk_i),
        .nrst_i(nrst_i),
        .d_i({scl_i, sda_i, core_r.snap_tgl}),
        .q_o({scl_s, sda_s, snap_tgl_s})
    );

    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        rise = scl_s & ~link_r.scl_d;
        fall = ~scl_s & link_r.scl_d;
        start = scl_s & link_r.scl_d & link_r.sda_d & ~sda_s;
        stop = scl_s & link_r.scl_d & ~link_r.sda_d & sda_s;
        link_nxt = link_r;
        link_nxt.scl_d = scl_s;
        link_nxt.sda_d = sda_s;
        if (snap_tgl_s != link_r.seen) begin
            link_nxt.status = core_r.snap;
            link_nxt.seen = snap_tgl_s;
        end
        if (start) begin
            link_nxt.state = hssf_pkg::L_ADDR;
            link_nxt.cnt = hssf_pkg::BIT_CNT_RST;
            link_nxt.sda_oen = 1'b1;
        end else if (stop) begin
            link_nxt.state = hssf_pkg::L_IDLE;
            link_nxt.sda_oen = 1'b1;
        end else begin
            unique case (link_r.state)
                hssf_pkg::L_IDLE: begin
                    link_nxt.sda_oen = 1'b1;
                end
                hssf_pkg::L_ADDR, hssf_pkg::L_WR: begin
                    if (rise) begin
                        link_nxt.shift = {link_r.shift[6:0], sda_s};
                        link_nxt.cnt = link_r.cnt + 4'h1;
                    end else if (fall && link_r.cnt == hssf_pkg::BITS_PER_BYTE) begin
                        link_nxt.cnt = hssf_pkg::BIT_CNT_RST;
                        if (link_r.state == hssf_pkg::L_WR) begin
                            link_nxt.state = hssf_pkg::L_ACKW;
                            link_nxt.sda_oen = 1'b0;
                            link_nxt.byte_idx = 1'b1;
                            if (!link_r.byte_idx) begin
                                link_nxt.wr_ptr = link_r.shift;
                            end else begin
                                link_nxt.wr_data = link_r.shift;
                                link_nxt.wr_tgl = ~link_r.wr_tgl;
                            end
                        end else if (link_r.shift[7:1] == DEV_ADDR) begin
                            link_nxt.state = hssf_pkg::L_ACKA;
                            link_nxt.sda_oen = 1'b0;
                            link_nxt.rw = link_r.shift[0];
                        end else begin
                            link_nxt.state = hssf_pkg::L_IDLE;
                        end
                    end
                end
                hssf_pkg::L_ACKA: begin
                    if (fall) begin
                        link_nxt.byte_idx = 1'b0;
                        if (link_r.rw) begin
                            link_nxt.state = hssf_pkg::L_RD;
                            link_nxt.tx = link_r.status;
                            link_nxt.sda_oen = link_r.status[7];
                        end else begin
                            link_nxt.state = hssf_pkg::L_WR;
                            link_nxt.sda_oen = 1'b1;
                        end
                    end
                end
                hssf_pkg::L_ACKW: begin
                    if (fall) begin
                        link_nxt.state = hssf_pkg::L_WR;
                        link_nxt.sda_oen = 1'b1;
                    end
                end
                hssf_pkg::L_RD: begin
                    if (rise) begin
                        link_nxt.cnt = link_r.cnt + 4'h1;
                    end else if (fall) begin
                        if (link_r.cnt == hssf_pkg::BITS_PER_BYTE) begin
                            link_nxt.state = hssf_pkg::L_ACKR;
                            link_nxt.sda_oen = 1'b1;
                        end else begin
                            link_nxt.tx = {link_r.tx[6:0], 1'b0};
                            link_nxt.sda_oen = link_r.tx[6];
                        end
                    end
                end
                hssf_pkg::L_ACKR: begin
                    if (rise) begin
                        link_nxt.nack = sda_s;
                    end else if (fall) begin
                        link_nxt.cnt = hssf_pkg::BIT_CNT_RST;
                        if (link_r.nack) begin
                            link_nxt.state = hssf_pkg::L_IDLE;
                        end else begin
                            link_nxt.state = hssf_pkg::L_RD;
                            link_nxt.tx = link_r.status;
                            link_nxt.sda_oen = link_r.status[7];
                        end
                    end
                end
                default: begin
                    link_nxt.state = hssf_pkg::L_IDLE;
                    link_nxt.sda_oen = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link_r <= '{
                state: hssf_pkg::L_IDLE,
                cnt: hssf_pkg::BIT_CNT_RST,
                shift: 8'h00,
                tx: 8'h00,
                rw: 1'b0,
                nack: 1'b0,
                sda_oen: 1'b1,
                sda_o: 1'b0,
                byte_idx: 1'b0,
                wr_ptr: 8'h00,
                wr_data: 8'h00,
                wr_tgl: 1'b0,
                status: hssf_pkg::STATUS_RST,
                seen: 1'b0,
                scl_d: 1'b1,
                sda_d: 1'b1
            };
        end else begin
            link_r <= link_nxt;
        end
    end

    assign sda_o = link_r.sda_o;
    assign sda_oen_o = link_r.sda_oen;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_clear_done;
        core_r.alert_en[hssf_pkg::AEN_CLEAR_BIT] ##1 !core_r.alert_en[hssf_pkg::AEN_CLEAR_BIT];
    endsequence

    sequence s_quiet_sources;
        !core_r.status.conversion_overcurrent_now && !pins_s.insert_fail && !core_r.status.off_status;
    endsequence

    a_oc_three_conv: assert property (@(posedge clk_i) disable iff (!nrst_i)
        core_r.status.conversion_overcurrent_now == (&core_r.oc_hist))
        else $error("Conversion overcurrent bit disagrees with last three results.");

    a_conv_alert_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        core_r.status.conv_alert && !core_r.alert_en[hssf_pkg::AEN_CLEAR_BIT] |=> core_r.status.conv_alert)
        else $error("Conversion alert dropped without a clear.");

    a_retry_trip_state: assert property (@(posedge clk_i) disable iff (!nrst_i)
        RETRY_VARIANT |=> core_r.status.analog_trip_off_state == $past(pins_s.analog_trip))
        else $error("Trip state does not follow the analog shutdown.");

    a_latch_trip_alert: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !RETRY_VARIANT && $past(core_r.alert_en[hssf_pkg::AEN_INS_BIT])
        |-> core_r.status.analog_trip_off_state == core_r.status.insertion_fail_alert)
        else $error("Trip state differs from insertion alert.");

    a_insert_fail_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
        pins_s.insert_fail |=> core_r.status.insertion_fail_alert)
        else $error("Insertion failure not flagged.");

    a_off_status_src: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ##1 core_r.status.off_status == $past(pin_deasserted | core_r.control[hssf_pkg::CTL_SW_OFF_BIT]))
        else $error("Off status does not follow pin and software-off.");

    a_off_alert_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
        core_r.status.off_status && core_r.alert_en[hssf_pkg::AEN_OFF_BIT] |=> core_r.status.off_alert)
        else $error("Off alert not raised.");

    a_clear_self_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        core_r.alert_en[hssf_pkg::AEN_CLEAR_BIT] && wr_tgl_s == core_r.wr_seen
        and s_quiet_sources |-> s_clear_done ##0 !core_r.status.conv_alert && !core_r.status.off_alert
            && !core_r.status.insertion_fail_alert)
        else $error("Clear bit did not clear sticky alerts and return to zero.");

    a_software_off_forces_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
        core_r.control[hssf_pkg::CTL_SW_OFF_BIT] |=> !hs_enable_o)
        else $error("Software-off did not turn the output off.");

    a_spare_bits_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        core_r.status.spare == 2'h0 && link_r.status[7:6] == 2'h0)
        else $error("Undefined status bits are not zero.");

    a_read_loads_byte: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
        link_r.state == hssf_pkg::L_ACKA && link_r.rw && !scl_s && link_r.scl_d && snap_tgl_s == link_r.seen
        |=> link_r.state == hssf_pkg::L_RD && link_r.tx == $past(link_r.status)
            && link_r.sda_oen == $past(link_r.status[7]))
        else $error("Read did not load the status byte.");
endmodule : hssf_top

// >>> hw/hssf_pkg.sv
package hssf_pkg;

    // Bit positions of the status byte.
    localparam int unsigned ST_CONV_OC_BIT = 0;
    localparam int unsigned ST_CONV_ALERT_BIT = 1;
    localparam int unsigned ST_TRIP_OFF_BIT = 2;
    localparam int unsigned ST_INS_ALERT_BIT = 3;
    localparam int unsigned ST_OFF_STATUS_BIT = 4;
    localparam int unsigned ST_OFF_ALERT_BIT = 5;

    // Register selectors carried in the first byte of a serial write.
    localparam logic [7:0] ALERT_EN_IDX = 8'h01;
    localparam logic [7:0] CONTROL_IDX = 8'h02;

    // Alert enable register fields.
    localparam int unsigned AEN_CONV_BIT = 0;
    localparam int unsigned AEN_INS_BIT = 1;
    localparam int unsigned AEN_OFF_BIT = 2;
    localparam int unsigned AEN_CLEAR_BIT = 4;

    // Control register fields.
    localparam int unsigned CTL_SW_OFF_BIT = 0;

    // Values after reset, and the bit count of one byte.
    localparam logic [7:0] ALERT_EN_RST = 8'h07;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [2:0] OC_HIST_RST = 3'h0;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Default seven-bit bus address of the device.
    localparam logic [6:0] DEV_ADDR_DEF = 7'h40;

    // Synchronised pin inputs of the core domain.
    typedef struct packed {
        logic enable_input_pin;
        logic conv_valid;
        logic conv_over;
        logic analog_trip;
        logic insert_fail;
    } hssf_pins_t;

    typedef struct packed {
        logic [1:0] spare;
        logic off_alert;
        logic off_status;
        logic insertion_fail_alert;
        logic analog_trip_off_state;
        logic conv_alert;
        logic conversion_overcurrent_now;
    } hssf_status_t;

    typedef enum logic [6:0] {
        L_IDLE = 7'h01,
        L_ADDR = 7'h02,
        L_ACKA = 7'h04,
        L_WR = 7'h08,
        L_ACKW = 7'h10,
        L_RD = 7'h20,
        L_ACKR = 7'h40
    } hssf_lstate_t;

    typedef struct packed {
        logic [2:0] oc_hist;
        logic conv_prev;
        hssf_status_t status;
        logic [7:0] alert_en;
        logic [7:0] control;
        logic wr_seen;
        logic [7:0] snap;
        logic snap_tgl;
        logic hs_on;
    } hssf_core_t;

    typedef struct packed {
        hssf_lstate_t state;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic rw;
        logic nack;
        logic sda_oen;
        logic sda_o;
        logic byte_idx;
        logic [7:0] wr_ptr;
        logic [7:0] wr_data;
        logic wr_tgl;
        logic [7:0] status;
        logic seen;
        logic scl_d;
        logic sda_d;
    } hssf_link_t;

endpackage : hssf_pkg

// >>> hw/hssf_sync.sv
`timescale 1ns/10ps

module hssf_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,              // Destination clock
    input wire logic nrst_i,             // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] d_i,    // Level from another domain
    output logic [WIDTH-1:0] q_o         // Synchronised level
);
    logic [1:0][WIDTH-1:0] stage_r;
    logic [1:0][WIDTH-1:0] stage_nxt;

    always_comb begin
        stage_nxt = {stage_r[0], d_i};
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // Both stages reset to the idle level of the source, so no false edge or level follows reset.
            stage_r <= {RST_VAL, RST_VAL};
        end else begin
            stage_r <= stage_nxt;
        end
    end

    assign q_o = stage_r[1];
endmodule : hssf_sync

// >>> dv/hssf_host_model.sv
`timescale 1ns/10ps

module hssf_host_model (
    input wire logic clk_i,   // Core clock, paces the bus phases
    input wire logic sda_i,   // Resolved data line
    output logic scl_o,       // Serial clock driven by the host
    output logic sda_o        // Host data drive, high releases the line
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Each phase is 200 ns, well above four link clock periods.
    task automatic half_p;
        repeat (8) @(negedge clk_i);
    endtask : half_p

    task automatic start_c;
        sda_o = 1'b1;
        scl_o = 1'b1;
        half_p;
        sda_o = 1'b0;
        half_p;
        scl_o = 1'b0;
        half_p;
    endtask : start_c

    task automatic stop_c;
        sda_o = 1'b0;
        half_p;
        scl_o = 1'b1;
        half_p;
        sda_o = 1'b1;
        half_p;
    endtask : stop_c

    task automatic bit_x(input logic b, output logic r);
        sda_o = b;
        half_p;
        scl_o = 1'b1;
        half_p;
        r = sda_i;
        scl_o = 1'b0;
        half_p;
    endtask : bit_x

    task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
    endtask : byte_x

    task automatic read_status(input logic [6:0] addr, output logic [7:0] st, output logic ack);
        logic [7:0] q;
        logic a;
        start_c;
        byte_x({addr, 1'b1}, q);
        bit_x(1'b1, a);
        ack = ~a;
        st = 8'hFF;
        if (ack) begin
            byte_x(8'hFF, st);
            bit_x(1'b1, a);
        end
        stop_c;
    endtask : read_status

    task automatic write_reg(input logic [7:0] sel, input logic [7:0] val, output logic ack);
        logic [7:0] q;
        logic a0;
        logic a1;
        logic a2;
        start_c;
        byte_x({hssf_pkg::DEV_ADDR_DEF, 1'b0}, q);
        bit_x(1'b1, a0);
        byte_x(sel, q);
        bit_x(1'b1, a1);
        byte_x(val, q);
        bit_x(1'b1, a2);
        stop_c;
        ack = ~(a0 | a1 | a2);
    endtask : write_reg
endmodule : hssf_host_model

// >>> dv/tb_hssf_top.sv
`timescale 1ns/10ps

module tb_hssf_top;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic en = 1'b1;
    logic cv = 1'b0;
    logic co = 1'b0;
    logic at = 1'b0;
    logic inf = 1'b0;
    localparam logic [6:0] LATCH_ADDR = hssf_pkg::DEV_ADDR_DEF ^ 7'h02;
    logic scl;
    logic host_sda;
    wire [1:0] sda_o;
    wire [1:0] sda_oen_o;
    wire [1:0] hs_en;
    wire sda_line;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] st;
    logic ack;

    // The line is pulled up; the host or either device may pull it low.
    assign sda_line = host_sda & (sda_oen_o[0] | sda_o[0]) & (sda_oen_o[1] | sda_o[1]);

    always #12.5 clk_i = ~clk_i;
    initial begin
        #7;
        forever #15 link_clk_i = ~link_clk_i;
    end

    // Device 0 retries and has an active-high enable; device 1 latches off, has an active-low enable fed the
    // inverse pin level, and sits at its own bus address.
    for (genvar v = 0; v < 2; v++) begin : g_dut
        hssf_top #(
            .RETRY_VARIANT(v == 0),
            .EN_ACTIVE_HIGH(v == 0),
            .DEV_ADDR((v == 0) ? hssf_pkg::DEV_ADDR_DEF : LATCH_ADDR)
        ) hssf_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .link_clk_i(link_clk_i),
            .enable_input_pin_i((v == 0) ? en : ~en), .conv_valid_i(cv), .conv_over_i(co), .analog_trip_i(at),
            .insert_fail_i(inf), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o[v]), .sda_oen_o(sda_oen_o[v]),
            .hs_enable_o(hs_en[v]));
    end
    hssf_host_model hssf_host_model_i (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            $display("unexpected at %0t: run did not finish", $time);
            print_verdict;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] exp);
        hssf_host_model_i.read_status(hssf_pkg::DEV_ADDR_DEF, st, ack);
        chk({7'h00, ack}, 8'h01);
        chk(st, exp);
    endtask : rd

    task automatic rd_latch(input logic [7:0] exp);
        hssf_host_model_i.read_status(LATCH_ADDR, st, ack);
        chk({7'h00, ack}, 8'h01);
        chk(st, exp);
    endtask : rd_latch

    task automatic wr(input logic [7:0] sel, input logic [7:0] val);
        hssf_host_model_i.write_reg(sel, val, ack);
        chk({7'h00, ack}, 8'h01);
        repeat (20) @(negedge clk_i);
    endtask : wr

    task automatic settle;
        repeat (20) @(negedge clk_i);
    endtask : settle

    task automatic conv(input logic over);
        co = over;
        repeat (4) @(negedge clk_i);
        cv = 1'b1;
        repeat (4) @(negedge clk_i);
        cv = 1'b0;
        settle;
    endtask : conv

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (10) @(negedge clk_i);
        rd(8'h00);
        chk({7'h00, hs_en[0]}, 8'h01);
        chk({7'h00, hs_en[1]}, 8'h01);
        conv(1'b1);
        conv(1'b1);
        rd(8'h00);
        conv(1'b1);
        rd(8'h03);
        conv(1'b0);
        rd(8'h02);
        rd_latch(8'h02);
        wr(hssf_pkg::ALERT_EN_IDX, 8'h17);
        rd(8'h00);
        inf = 1'b1;
        settle;
        inf = 1'b0;
        settle;
        rd(8'h08);
        at = 1'b1;
        settle;
        rd(8'h0C);
        rd_latch(8'h0E);
        at = 1'b0;
        settle;
        rd(8'h08);
        rd_latch(8'h0E);
        inf = 1'b1;
        wr(hssf_pkg::ALERT_EN_IDX, 8'h17);
        rd(8'h08);
        inf = 1'b0;
        wr(hssf_pkg::ALERT_EN_IDX, 8'h17);
        rd(8'h00);
        en = 1'b0;
        settle;
        rd(8'h30);
        rd_latch(8'h3E);
        chk({7'h00, hs_en[0]}, 8'h00);
        chk({7'h00, hs_en[1]}, 8'h00);
        en = 1'b1;
        settle;
        rd(8'h20);
        chk({7'h00, hs_en[0]}, 8'h01);
        wr(hssf_pkg::ALERT_EN_IDX, 8'h17);
        rd(8'h00);
        wr(hssf_pkg::CONTROL_IDX, 8'h01);
        rd(8'h30);
        chk({7'h00, hs_en[0]}, 8'h00);
        wr(hssf_pkg::CONTROL_IDX, 8'h00);
        wr(hssf_pkg::ALERT_EN_IDX, 8'h17);
        rd(8'h00);
        wr(8'h05, 8'hFF);
        rd(8'h00);
        hssf_host_model_i.read_status(hssf_pkg::DEV_ADDR_DEF ^ 7'h01, st, ack);
        chk({7'h00, ack}, 8'h00);
        print_verdict;
    end
endmodule : tb_hssf_top
